// ---- rtl/ldct_map.svh ----
/*
 * Register offsets, field positions, reset values and prescale counts
 * of the dual counter/timer.
 * Assumes it is included by its bare name before use.
 */
`ifndef LDCT_MAP_SVH
`define LDCT_MAP_SVH

// special-function register offsets
`define LDCT_ADDR_CTRL      8'h88
`define LDCT_ADDR_MODE      8'h89
`define LDCT_ADDR_TL0       8'h8a
`define LDCT_ADDR_TL1       8'h8b
`define LDCT_ADDR_TH0       8'h8c
`define LDCT_ADDR_TH1       8'h8d
`define LDCT_ADDR_CLK       8'h8e

// timer_control_status fields
`define LDCT_TF1            7
`define LDCT_TR1            6
`define LDCT_TF0            5
`define LDCT_TR0            4
`define LDCT_IE1            3
`define LDCT_IT1            2
`define LDCT_IE0            1
`define LDCT_IT0            0

// timer_mode_register fields
`define LDCT_SECOND_GATE_BIT          7
`define LDCT_CT1            6
`define LDCT_MD1_HI         5
`define LDCT_MD1_LO         4
`define LDCT_FIRST_GATE_BIT          3
`define LDCT_CT0            2
`define LDCT_MD0_HI         1
`define LDCT_MD0_LO         0

// clock_select_register fields
`define LDCT_T1M            3
`define LDCT_T0M            2
`define LDCT_SCA_HI         1
`define LDCT_SCA_LO         0

// reset values
`define LDCT_RST_BYTE       8'h00

// prescale divisors, in system clocks or external clock edges
`define LDCT_DIV12          6'h0c
`define LDCT_DIV4           6'h04
`define LDCT_DIV48          6'h30
`define LDCT_EXT_LAST       3'h7

`endif

// ---- rtl/ldct_pkg.sv ----
/*
 * Types shared by the dual counter/timer modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package ldct_pkg;

	// two-bit mode field encodings
	typedef enum logic [1:0] {
		LDCT_MODE13  = 2'b00,
		LDCT_MODE16  = 2'b01,
		LDCT_MODE8AR = 2'b10,
		LDCT_MODE3   = 2'b11
	} ldct_mode_t;

	// whole register state of the timer block
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] clk;
		logic [7:0] tl0;
		logic [7:0] th0;
		logic [7:0] tl1;
		logic [7:0] th1;
		logic [5:0] pre_cnt;
		logic [2:0] ext_cnt;
		logic [7:0] rdata;
		logic       ovf1_pulse;
	} ldct_state_t;

	// state of the pin synchroniser
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] s3;
	} ldct_sync_t;

endpackage : ldct_pkg

`default_nettype wire

// ---- rtl/ldct_sync.sv ----
/*
 * Two-flop synchroniser with edge detection for the timer pins.
 * Assumes asynchronous pin levels held for two or more system clocks.
 */
`default_nettype none

module ldct_sync #(
	parameter int WIDTH = 5
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// pins
	input  wire logic [WIDTH-1:0] din,
	// synchronised view
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	ldct_pkg::ldct_sync_t st;

	// s1 feeds only s2; edges come from s2 against s3
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			st <= '0;
		else if (ce)
			st <= '{s1: din[4:0], s2: st.s1, s3: st.s2};
	end

	// compare successive synchronised samples
	assign level = st.s2;
	assign rise  = st.s2 & ~st.s3;
	assign fall  = st.s3 & ~st.s2;

endmodule : ldct_sync

`default_nettype wire

// ---- rtl/ldct_top.sv ----
/*
 * Two legacy 13/16/8-bit counter/timers with shared control register,
 * prescaler and external interrupt flags, on the special-function bus.
 * Assumes the processor core supplies vector acknowledges, the enable
 * and polarity bits, and single-cycle read and write strobes.
 */
// Notes on behaviour
// - counter function counts each falling edge on the event pin
// - event edges up to a quarter of system clock are counted
// - 13-bit mode: high byte top eight bits, low byte bits 4..0
// - 13-bit wrap to zero sets overflow flag, may raise interrupt
// - count select picks pin edges, else system or prescaled clock
// - outside split, counts only when run set and gate off or input active
// - setting run never clears or reloads the count
// - second timer mirrors first with its own bits and input b
// - 16-bit mode uses full byte pair, wrap sets overflow flag
// - 8-bit reload: low byte counts, wrap reloads from high byte
// - split mode: first low byte is its own 8-bit counter/timer
// - split: first high byte timer-only, second run bit and flag
// - split: second timer no events, no flag, still pulses out
// - second timer stops in mode 3, runs in 0..2 during split
// - overflow flag set by hardware, cleared by write or vector
// - ext flag: edge sticky until clear, level follows the input
// - type bit 0 means level trigger, 1 means edge trigger
// - timer request reaches core only with its enable bit set
// - mode field: 13-bit, 16-bit, 8-bit reload, split/inactive
// - prescale: divide by 12, 4, 48, or external clock by 8
// - mode register: second timer bits 7..4, first bits 3..0
// - clock select: second at bit 3, first at bit 2
`default_nettype none
`include "ldct_map.svh"

module ldct_top (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// special-function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// pins
	input  wire logic       first_event_pin,
	input  wire logic       second_event_pin,
	input  wire logic       ext_irq_a_input,
	input  wire logic       ext_irq_b_input,
	input  wire logic       ext_clk_in,
	// configuration held by the core
	input  wire logic       ext_irq_a_polarity,
	input  wire logic       ext_irq_b_polarity,
	input  wire logic       first_timer_irq_enable,
	input  wire logic       second_timer_irq_enable,
	// vector acknowledges from the core
	input  wire logic       first_timer_vector,
	input  wire logic       second_timer_vector,
	input  wire logic       ext_irq_a_vector,
	input  wire logic       ext_irq_b_vector,
	// requests and overflow pulse
	output logic            first_timer_irq,
	output logic            second_timer_irq,
	output logic            ext_irq_a_flag,
	output logic            ext_irq_b_flag,
	output logic            second_overflow_pulse
);

	ldct_pkg::ldct_state_t st;
	ldct_pkg::ldct_state_t nxt;

	logic [4:0]  pin_lvl;
	logic [4:0]  pin_rise;
	logic [4:0]  pin_fall;
	logic        a_active;
	logic        b_active;
	logic        a_edge;
	logic        b_edge;
	logic        pre_ext;
	logic [5:0]  pre_div;
	logic        pre_tick;
	logic        split;
	logic [1:0]  md0;
	logic [1:0]  md1;
	logic        inc0;
	logic        inc1;
	logic        inc_h;
	logic [16:0] step0;
	logic [16:0] step1;
	logic        ovf0;
	logic        ovf1;
	logic        ovf_h;
	logic        wr_ctrl;

	// one step of a timer: returns {overflow, high, low}
	function automatic logic [16:0] ldct_step(
		input logic [1:0] md,
		input logic [7:0] tl,
		input logic [7:0] th,
		input logic       inc
	);
		logic [12:0] c13;
		logic [15:0] c16;
		logic [7:0]  c8;
		c13 = {th, tl[4:0]} + 13'h0001;
		c16 = {th, tl} + 16'h0001;
		c8  = tl + 8'h01;
		if (!inc)
			ldct_step = {1'b0, th, tl};
		else
			case (md)
				// upper low-byte bits are left alone
				ldct_pkg::LDCT_MODE13:
					ldct_step = {&{th, tl[4:0]}, c13[12:5],
						tl[7:5], c13[4:0]};
				ldct_pkg::LDCT_MODE16:
					ldct_step = {&{th, tl}, c16};
				ldct_pkg::LDCT_MODE8AR:
					ldct_step = (&tl) ? {1'b1, th, th}
						: {1'b0, th, c8};
				default:
					ldct_step = {&tl, th, c8};
			endcase
	endfunction : ldct_step

	// all pins pass the two-flop synchroniser first
	ldct_sync #(
		.WIDTH (5)
	) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.ce    (ce),
		.din   ({ext_clk_in, ext_irq_b_input, ext_irq_a_input,
			second_event_pin, first_event_pin}),
		.level (pin_lvl),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	// interrupt inputs at their configured polarity
	assign a_active = ext_irq_a_polarity ? pin_lvl[2] : ~pin_lvl[2];
	assign b_active = ext_irq_b_polarity ? pin_lvl[3] : ~pin_lvl[3];
	assign a_edge   = ext_irq_a_polarity ? pin_rise[2] : pin_fall[2];
	assign b_edge   = ext_irq_b_polarity ? pin_rise[3] : pin_fall[3];

	// shared prescaler; >= recovers if the field shrinks mid-count
	assign pre_ext = (st.clk[`LDCT_SCA_HI:`LDCT_SCA_LO] == 2'b11);
	assign pre_div = (st.clk[`LDCT_SCA_HI:`LDCT_SCA_LO] == 2'b00)
		? `LDCT_DIV12
		: (st.clk[`LDCT_SCA_LO] ? `LDCT_DIV4 : `LDCT_DIV48);
	assign pre_tick = pre_ext
		? (pin_rise[4] && st.ext_cnt == `LDCT_EXT_LAST)
		: (st.pre_cnt >= pre_div - 6'h01);

	// mode decode
	assign md0   = st.mode[`LDCT_MD0_HI:`LDCT_MD0_LO];
	assign md1   = st.mode[`LDCT_MD1_HI:`LDCT_MD1_LO];
	assign split = (md0 == ldct_pkg::LDCT_MODE3);

	// first timer enable and source
	assign inc0 = st.ctrl[`LDCT_TR0]
		& (~st.mode[`LDCT_FIRST_GATE_BIT] | a_active)
		& (st.mode[`LDCT_CT0] ? pin_fall[0]
			: (st.clk[`LDCT_T0M] | pre_tick));

	// split high byte: timer only, under the second run bit
	assign inc_h = split & st.ctrl[`LDCT_TR1]
		& (st.clk[`LDCT_T0M] | pre_tick);

	// second timer; during split its run follows the mode
	assign inc1 = (split | st.ctrl[`LDCT_TR1])
		& (~st.mode[`LDCT_SECOND_GATE_BIT] | b_active)
		& (md1 != ldct_pkg::LDCT_MODE3)
		& ((st.mode[`LDCT_CT1] & ~split) ? pin_fall[1]
			: (st.clk[`LDCT_T1M] | pre_tick));

	assign step0 = ldct_step(md0, st.tl0, st.th0, inc0);
	assign step1 = ldct_step(md1, st.tl1, st.th1, inc1);
	assign ovf0  = step0[16];
	assign ovf1  = step1[16];
	assign ovf_h = inc_h & (&st.th0);
	assign wr_ctrl = sfr_wr && sfr_addr == `LDCT_ADDR_CTRL;

	// next-state: counting, then software writes, then flags
	always_comb
	begin
		nxt = st;
		// prescaler counters
		if (pre_ext)
		begin
			nxt.pre_cnt = 6'h00;
			if (pin_rise[4])
				nxt.ext_cnt = st.ext_cnt + 3'h1;
		end
		else
		begin
			nxt.ext_cnt = 3'h0;
			nxt.pre_cnt = pre_tick ? 6'h00 : st.pre_cnt + 6'h01;
		end
		// counters; run bit alone never touches the count
		nxt.tl0 = step0[7:0];
		nxt.th0 = split ? st.th0 + {7'h00, inc_h} : step0[15:8];
		nxt.tl1 = step1[7:0];
		nxt.th1 = step1[15:8];
		nxt.ovf1_pulse = ovf1;
		// a software write wins over a count in the same cycle
		if (sfr_wr)
			case (sfr_addr)
				`LDCT_ADDR_MODE: nxt.mode = sfr_wdata;
				`LDCT_ADDR_CLK:  nxt.clk  = sfr_wdata;
				`LDCT_ADDR_TL0:  nxt.tl0  = sfr_wdata;
				`LDCT_ADDR_TH0:  nxt.th0  = sfr_wdata;
				`LDCT_ADDR_TL1:  nxt.tl1  = sfr_wdata;
				`LDCT_ADDR_TH1:  nxt.th1  = sfr_wdata;
				default:         nxt.mode = st.mode;
			endcase
		// control register: write, then vector clears, then sets
		if (wr_ctrl)
			nxt.ctrl = sfr_wdata;
		if (first_timer_vector)
			nxt.ctrl[`LDCT_TF0] = 1'b0;
		if (second_timer_vector)
			nxt.ctrl[`LDCT_TF1] = 1'b0;
		if (ext_irq_a_vector && st.ctrl[`LDCT_IT0])
			nxt.ctrl[`LDCT_IE0] = 1'b0;
		if (ext_irq_b_vector && st.ctrl[`LDCT_IT1])
			nxt.ctrl[`LDCT_IE1] = 1'b0;
		// hardware sets come last so they win
		if (ovf0)
			nxt.ctrl[`LDCT_TF0] = 1'b1;
		if (split ? ovf_h : ovf1)
			nxt.ctrl[`LDCT_TF1] = 1'b1;
		// edge type sticky, level type follows input
		if (st.ctrl[`LDCT_IT0])
			nxt.ctrl[`LDCT_IE0] = nxt.ctrl[`LDCT_IE0] | a_edge;
		else
			nxt.ctrl[`LDCT_IE0] = a_active;
		if (st.ctrl[`LDCT_IT1])
			nxt.ctrl[`LDCT_IE1] = nxt.ctrl[`LDCT_IE1] | b_edge;
		else
			nxt.ctrl[`LDCT_IE1] = b_active;
		// registered read data; unmapped offsets read zero
		if (sfr_rd)
			case (sfr_addr)
				`LDCT_ADDR_CTRL: nxt.rdata = st.ctrl;
				`LDCT_ADDR_MODE: nxt.rdata = st.mode;
				`LDCT_ADDR_CLK:  nxt.rdata = st.clk;
				`LDCT_ADDR_TL0:  nxt.rdata = st.tl0;
				`LDCT_ADDR_TH0:  nxt.rdata = st.th0;
				`LDCT_ADDR_TL1:  nxt.rdata = st.tl1;
				`LDCT_ADDR_TH1:  nxt.rdata = st.th1;
				default:         nxt.rdata = 8'h00;
			endcase
	end

	// single state register, frozen while ce is low
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			st <= '0;
		else if (ce)
			st <= nxt;
	end

	// outputs; requests gated by the core's enable bits
	assign sfr_rdata             = st.rdata;
	assign first_timer_irq       = st.ctrl[`LDCT_TF0] & first_timer_irq_enable;
	assign second_timer_irq      = st.ctrl[`LDCT_TF1]
		& second_timer_irq_enable;
	assign ext_irq_a_flag        = st.ctrl[`LDCT_IE0];
	assign ext_irq_b_flag        = st.ctrl[`LDCT_IE1];
	assign second_overflow_pulse = st.ovf1_pulse;

	// overflow always lands in the flag
	first_flag_set_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		ce && ovf0 |=> st.ctrl[`LDCT_TF0])
		else $error("first overflow did not set its flag");

	// a clear written in the overflow cycle loses
	set_beats_clear_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		ce && ovf0 && wr_ctrl && !sfr_wdata[`LDCT_TF0]
		|=> st.ctrl[`LDCT_TF0])
		else $error("software clear beat hardware set");

	// request follows a rising flag only when enabled
	irq_gate_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(st.ctrl[`LDCT_TF0]) && !first_timer_irq_enable
		|-> !first_timer_irq)
		else $error("timer request passed without enable");

	// stopped timer keeps its value
	run_hold_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		ce && !st.ctrl[`LDCT_TR0] && !split && !sfr_wr
		|=> st.tl0 == $past(st.tl0) && st.th0 == $past(st.th0))
		else $error("first timer moved while stopped");

	// 8-bit wrap reloads from the high byte
	reload_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		ce && md0 == 2'b10 && inc0 && st.tl0 == 8'hff && !sfr_wr
		|=> st.tl0 == $past(st.th0) && st.th0 == $past(st.th0)
			&& st.ctrl[`LDCT_TF0])
		else $error("auto-reload did not reload");

	// each falling pin edge adds one in 16-bit counter mode
	event_count_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		ce && md0 == 2'b01 && st.mode[`LDCT_CT0] && st.ctrl[`LDCT_TR0]
			&& !st.mode[`LDCT_FIRST_GATE_BIT] && pin_fall[0] && !sfr_wr
		|=> {st.th0, st.tl0} == $past({st.th0, st.tl0}) + 16'h0001)
		else $error("event edge not counted");

	// second timer in mode 3 is frozen
	mode3_stop_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		ce && md1 == 2'b11 && !sfr_wr
		|=> st.tl1 == $past(st.tl1) && st.th1 == $past(st.th1)
			&& !st.ovf1_pulse)
		else $error("second timer counted in mode 3");

	// level type flag mirrors the active input
	level_flag_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		ce && !st.ctrl[`LDCT_IT0] |=> ext_irq_a_flag == $past(a_active))
		else $error("level flag does not follow input");

	// split: second timer overflow leaves its flag alone
	split_noflag_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		ce && split && ovf1 && !ovf_h && !st.ctrl[`LDCT_TF1] && !wr_ctrl
		|=> !st.ctrl[`LDCT_TF1] && second_overflow_pulse)
		else $error("split mode second overflow misbehaved");

endmodule : ldct_top

`default_nettype wire

// ---- tb/ldct_pins_model.sv ----
/*
 * Far-side model of the timer pins: event pins and gate inputs.
 * Assumes the bench calls its tasks from one process at a time.
 */
`default_nettype none

module ldct_pins_model (
	// clock
	input  wire logic clock,
	// pins toward the block
	output var  logic first_event_pin,
	output var  logic second_event_pin,
	output var  logic ext_irq_a_input,
	output var  logic ext_irq_b_input
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle levels: event pins high, gate inputs low
	initial
	begin
		first_event_pin = 1'b1;
		second_event_pin = 1'b1;
		ext_irq_a_input = 1'b0;
		ext_irq_b_input = 1'b0;
	end

	// each level held two clocks, the fastest legal rate
	task automatic events(input logic sel, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clock);
			#1;
			if (sel) second_event_pin = 1'b0;
			else first_event_pin = 1'b0;
			repeat (2) @(posedge clock);
			#1;
			if (sel) second_event_pin = 1'b1;
			else first_event_pin = 1'b1;
			@(posedge clock);
		end
	endtask : events

	// gate inputs change just after an edge
	task automatic gate(input logic a, input logic b);
		@(posedge clock);
		#1;
		ext_irq_a_input = a;
		ext_irq_b_input = b;
	endtask : gate

endmodule : ldct_pins_model

`default_nettype wire

// ---- tb/tb_top.sv ----
/*
 * Self-checking bench of the dual counter/timer.
 * Assumes ldct_map.svh on the include path and the pins model.
 */
`default_nettype none
`include "ldct_map.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic       clock, rst_n, sfr_wr, sfr_rd, pol_a, pol_b, en0, en1;
	logic       vec0, vec1, veca, vecb;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic       irq0, irq1, flag_a, flag_b, ovf1;
	logic       ev0, ev1, in_a, in_b, ext_clk;
	int         errors, tests_run, cycle_cnt;

	ldct_pins_model u_ldct_pins_model (.clock(clock),
		.first_event_pin(ev0), .second_event_pin(ev1),
		.ext_irq_a_input(in_a), .ext_irq_b_input(in_b));

	ldct_top u_ldct_top (.clock(clock), .rst_n(rst_n), .ce(1'b1),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.first_event_pin(ev0), .second_event_pin(ev1),
		.ext_irq_a_input(in_a), .ext_irq_b_input(in_b),
		.ext_clk_in(ext_clk), .ext_irq_a_polarity(pol_a),
		.ext_irq_b_polarity(pol_b), .first_timer_irq_enable(en0),
		.second_timer_irq_enable(en1), .first_timer_vector(vec0),
		.second_timer_vector(vec1), .ext_irq_a_vector(veca),
		.ext_irq_b_vector(vecb), .first_timer_irq(irq0),
		.second_timer_irq(irq1), .ext_irq_a_flag(flag_a),
		.ext_irq_b_flag(flag_b), .second_overflow_pulse(ovf1));

	// clock
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// free-running external clock, four system clocks a period
	always
	begin
		@(posedge clock);
		#1;
		ext_clk = cycle_cnt[1];
	end

	// hang guard, far above the roughly 700 cycles used
	always @(posedge clock)
	begin
		cycle_cnt++;
		if (cycle_cnt >= 20000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk8(input string n, input logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk8

	task automatic chk1(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("mismatch %s expected %b seen %b", n, e, g);
		end
	endtask : chk1

	// one write strobe, released after the taking edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clock);
		#1;
		sfr_wr = 1'b0;
	endtask : wr

	// read data is registered at the taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clock);
		#1;
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask : rd

	task automatic rdchk(input logic [7:0] a, e, input logic [7:0] m);
		logic [7:0] d;
		repeat (4) @(posedge clock);
		rd(a, d);
		chk8($sformatf("reg %h", a), e, d & m);
	endtask : rdchk

	task automatic pulse(ref logic s);
		@(posedge clock);
		#1;
		s = 1'b1;
		@(posedge clock);
		#1;
		s = 1'b0;
	endtask : pulse

	task automatic t_reset();
		for (int a = 8'h88; a <= 8'h90; a++)
			if (a != 8'h8f) rdchk(8'(a), 8'h00, 8'hff);
		chk1("first_timer_irq", 1'b0, irq0);
	endtask : t_reset

	task automatic t_count16();
		wr(`LDCT_ADDR_MODE, 8'h05);
		wr(`LDCT_ADDR_TL0, 8'hfe);
		wr(`LDCT_ADDR_TH0, 8'hff);
		wr(`LDCT_ADDR_CTRL, 8'h10);
		u_ldct_pins_model.events(1'b0, 3);
		rdchk(`LDCT_ADDR_TL0, 8'h01, 8'hff);
		rdchk(`LDCT_ADDR_TH0, 8'h00, 8'hff);
		rdchk(`LDCT_ADDR_CTRL, 8'h30, 8'hff);
		chk1("first_timer_irq", 1'b0, irq0);
		en0 = 1'b1;
		#1 chk1("first_timer_irq", 1'b1, irq0);
		pulse(vec0);
		rdchk(`LDCT_ADDR_CTRL, 8'h10, 8'hff);
		en0 = 1'b0;
	endtask : t_count16

	task automatic t_mode13();
		wr(`LDCT_ADDR_CTRL, 8'h00);
		wr(`LDCT_ADDR_MODE, 8'h40);
		wr(`LDCT_ADDR_TL1, 8'h1e);
		wr(`LDCT_ADDR_TH1, 8'hff);
		wr(`LDCT_ADDR_CTRL, 8'h40);
		u_ldct_pins_model.events(1'b1, 2);
		rdchk(`LDCT_ADDR_TL1, 8'h00, 8'h1f);
		rdchk(`LDCT_ADDR_TH1, 8'h00, 8'hff);
		rdchk(`LDCT_ADDR_CTRL, 8'hc0, 8'hff);
		en1 = 1'b1;
		#1 chk1("second_timer_irq", 1'b1, irq1);
		en1 = 1'b0;
		wr(`LDCT_ADDR_CTRL, 8'h40);
		rdchk(`LDCT_ADDR_CTRL, 8'h40, 8'hff);
	endtask : t_mode13

	task automatic t_reload();
		wr(`LDCT_ADDR_CTRL, 8'h00);
		wr(`LDCT_ADDR_MODE, 8'h06);
		wr(`LDCT_ADDR_TH0, 8'h80);
		wr(`LDCT_ADDR_TL0, 8'hff);
		wr(`LDCT_ADDR_CTRL, 8'h10);
		u_ldct_pins_model.events(1'b0, 2);
		rdchk(`LDCT_ADDR_TL0, 8'h81, 8'hff);
		rdchk(`LDCT_ADDR_TH0, 8'h80, 8'hff);
		rdchk(`LDCT_ADDR_CTRL, 8'h30, 8'hff);
	endtask : t_reload

	// gate closed, gate open, run off, run on again
	task automatic t_gate_run();
		wr(`LDCT_ADDR_CTRL, 8'h00);
		wr(`LDCT_ADDR_MODE, 8'h0d);
		wr(`LDCT_ADDR_TL0, 8'h00);
		wr(`LDCT_ADDR_CTRL, 8'h10);
		u_ldct_pins_model.events(1'b0, 2);
		rdchk(`LDCT_ADDR_TL0, 8'h00, 8'hff);
		u_ldct_pins_model.gate(1'b1, 1'b0);
		u_ldct_pins_model.events(1'b0, 2);
		rdchk(`LDCT_ADDR_TL0, 8'h02, 8'hff);
		wr(`LDCT_ADDR_CTRL, 8'h00);
		u_ldct_pins_model.events(1'b0, 2);
		rdchk(`LDCT_ADDR_TL0, 8'h02, 8'hff);
		wr(`LDCT_ADDR_CTRL, 8'h10);
		u_ldct_pins_model.events(1'b0, 1);
		rdchk(`LDCT_ADDR_TL0, 8'h03, 8'hff);
		u_ldct_pins_model.gate(1'b0, 1'b0);
	endtask : t_gate_run

	task automatic t_split();
		logic [7:0] d;
		logic       seen;
		wr(`LDCT_ADDR_CTRL, 8'h00);
		wr(`LDCT_ADDR_MODE, 8'h37);
		wr(`LDCT_ADDR_CLK, 8'h0c);
		wr(`LDCT_ADDR_TL1, 8'h00);
		wr(`LDCT_ADDR_TL0, 8'hff);
		wr(`LDCT_ADDR_TH0, 8'hfe);
		wr(`LDCT_ADDR_CTRL, 8'h10);
		u_ldct_pins_model.events(1'b0, 1);
		rdchk(`LDCT_ADDR_TL0, 8'h00, 8'hff);
		rdchk(`LDCT_ADDR_TH0, 8'hfe, 8'hff);
		rdchk(`LDCT_ADDR_CTRL, 8'h30, 8'hff);
		wr(`LDCT_ADDR_CTRL, 8'h50);
		rdchk(`LDCT_ADDR_CTRL, 8'h80, 8'h80);
		rdchk(`LDCT_ADDR_TL1, 8'h00, 8'hff);
		// run bit off: second timer still runs in split, without flag
		wr(`LDCT_ADDR_CTRL, 8'h10);
		wr(`LDCT_ADDR_MODE, 8'h27);
		wr(`LDCT_ADDR_TH1, 8'hf0);
		wr(`LDCT_ADDR_TL1, 8'hf0);
		seen = 1'b0;
		repeat (40)
		begin
			@(posedge clock);
			#1;
			seen |= ovf1;
		end
		chk1("second_overflow_pulse", 1'b1, seen);
		rdchk(`LDCT_ADDR_CTRL, 8'h00, 8'h80);
		rd(`LDCT_ADDR_TL1, d);
		chk1("second timer runs", 1'b1, d != 8'h00);
	endtask : t_split

	// two reads exactly n cycles apart give the tick count
	task automatic t_prescale();
		logic [7:0] ck[5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h03};
		int         n[5] = '{48, 40, 96, 20, 64};
		logic [7:0] e[5] = '{8'h04, 8'h0a, 8'h02, 8'h14, 8'h02};
		logic [7:0] d0, d1;
		wr(`LDCT_ADDR_CTRL, 8'h00);
		wr(`LDCT_ADDR_MODE, 8'h01);
		wr(`LDCT_ADDR_CTRL, 8'h10);
		for (int i = 0; i < 5; i++)
		begin
			wr(`LDCT_ADDR_CLK, ck[i]);
			rd(`LDCT_ADDR_TL0, d0);
			repeat (n[i] - 2) @(posedge clock);
			rd(`LDCT_ADDR_TL0, d1);
			chk8("ticks", e[i], d1 - d0);
		end
	endtask : t_prescale

	task automatic t_extirq();
		wr(`LDCT_ADDR_CTRL, 8'h01);
		u_ldct_pins_model.gate(1'b1, 1'b0);
		rdchk(`LDCT_ADDR_CTRL, 8'h03, 8'hff);
		u_ldct_pins_model.gate(1'b0, 1'b0);
		rdchk(`LDCT_ADDR_CTRL, 8'h03, 8'hff);
		chk1("ext_irq_a_flag", 1'b1, flag_a);
		pulse(veca);
		rdchk(`LDCT_ADDR_CTRL, 8'h01, 8'hff);
		wr(`LDCT_ADDR_CTRL, 8'h00);
		u_ldct_pins_model.gate(1'b1, 1'b0);
		rdchk(`LDCT_ADDR_CTRL, 8'h02, 8'hff);
		u_ldct_pins_model.gate(1'b0, 1'b0);
		rdchk(`LDCT_ADDR_CTRL, 8'h00, 8'hff);
		pol_b = 1'b0;
		rdchk(`LDCT_ADDR_CTRL, 8'h08, 8'hff);
		chk1("ext_irq_b_flag", 1'b1, flag_b);
		pol_b = 1'b1;
	endtask : t_extirq

	initial
	begin
		{sfr_wr, sfr_rd, en0, en1, vec0, vec1, veca, vecb} = 8'h00;
		{sfr_addr, sfr_wdata} = 16'h0000;
		{pol_a, pol_b} = 2'b11;
		{errors, tests_run, cycle_cnt} = {32'h0, 32'h0, 32'h0};
		rst_n = 1'b0;
		repeat (2) @(posedge clock);
		#1 rst_n = 1'b1;
		t_reset();
		t_count16();
		t_mode13();
		t_reload();
		t_gate_run();
		t_split();
		t_prescale();
		t_extirq();
		tally_and_finish();
	end

endmodule : tb_top

`default_nettype wire
